// *** clkgen_pkg.sv ***
package clkgen_pkg;
  // ********************
  // register map
  // ********************
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_MULT = 8'h04;
  localparam logic [7:0] OFS_FILT = 8'h08;
  localparam logic [7:0] OFS_STAT = 8'h0C;
  localparam logic [7:0] OFS_TUNE = 8'h10;
  // ********************
  // fields
  // ********************
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_RANGE    = 2;
  localparam int CTRL_GAIN     = 3;
  localparam int CTRL_LOSSRST  = 4;
  localparam int CTRL_STOPOFF  = 5;
  localparam int CTRL_RTIEN    = 6;
  localparam int MULT_LSB      = 0;
  localparam int DIV_LSB       = 8;
  localparam int FILT_LSB      = 0;
  localparam int TRIM_LSB      = 16;
  localparam int ST_LOCK       = 0;
  localparam int ST_LOL        = 1;
  localparam int ST_LOC        = 2;
  localparam int ST_EXTOK      = 3;
  localparam int ST_MODE_LSB   = 8;
  // ********************
  // reset values
  // ********************
  localparam logic [6:0]  MULT_RST = 7'h08;
  localparam logic [2:0]  DIV_RST  = 3'h0;
  localparam logic [11:0] FILT_RST = 12'h400;
  localparam logic [7:0]  TRIM_RST = 8'h80;
  // ********************
  // timing
  // ********************
  localparam int SYS_MHZ        = 100;
  localparam int EXT_LOSS_NS_LO = 40000;
  localparam int EXT_LOSS_NS_HI = 2000;
  localparam int EXT_LOSS_LO    = EXT_LOSS_NS_LO * SYS_MHZ / 1000;
  localparam int EXT_LOSS_HI    = EXT_LOSS_NS_HI * SYS_MHZ / 1000;
  localparam int IREF_HALF_NS   = 2058;
  localparam int IREF_HALF      = IREF_HALF_NS * SYS_MHZ / 1000;
  localparam int RTI_PERIOD_US  = 1000;
  localparam int RTI_CYCLES     = RTI_PERIOD_US * SYS_MHZ;
  localparam int DBG_HALF       = 6;
  localparam int LOCK_REPEAT    = 4;
  localparam int LOCK_TOL       = 2;
  localparam logic [15:0] TUNE_STEP = 16'h0010;
  localparam int FLL_MIN_MHZ    = 8;
  localparam int FLL_MAX_MHZ    = 40;
  localparam int BUS_MAX_MHZ    = 20;
  // ********************
  // modes
  // ********************
  localparam logic [1:0] REQ_SCM = 2'h0;
  localparam logic [1:0] REQ_FEI = 2'h1;
  localparam logic [1:0] REQ_FBE = 2'h2;
  localparam logic [1:0] REQ_FEE = 2'h3;
  typedef enum logic [4:0] {
    M_OFF = 5'h01,
    M_SCM = 5'h02,
    M_FEI = 5'h04,
    M_FBE = 5'h08,
    M_FEE = 5'h10
  } mode_t;
endpackage : clkgen_pkg

// *** clock_generator.sv ***
// Chosen here: the register offsets and the APB slave port.
`timescale 1ns/100ps
// How it works
// RQ1: low and high crystal range select
// RQ2: reset enters self-clocked mode
// RQ3: loop output 8-40 MHz, bus 20
// RQ4: software caps loop with radio clock
// RQ5: non-running sources cannot be selected
// RQ6: clock or lock loss gives reset/irq
// RQ7: oscillator setting kept through stop
// RQ8: oscillator holds when reference vanishes
// RQ9: engaged loss adds divide by two
// RQ10: post divider /1 to /128
// RQ11: real-time tick from own source
// RQ12: internal reference trimmable by software
// RQ13: loop output switched in after lock
// RQ14: low-power or high-gain drive choice
// RQ15: off mode holds output static
// RQ16: self-clocked runs open at filter
// RQ17: engaged-internal multiplies internal reference
// RQ18: internal engaged adjusts then locks
// RQ19: bypassed mode uses external clock
// RQ20: engaged-external multiplies external reference
// RQ21: external engaged adjusts then locks
// RQ22: multiplied, reference, fixed, debug outputs
// RQ23: slow internal reference near 243 kHz
// RQ24: high gain select drives oscillator
// RQ25: sticky flags, glitchless source change
module clock_generator #(
  parameter int RTI_COUNT = clkgen_pkg::RTI_CYCLES
) (
  input  wire logic        SYS_CLK,
  input  wire logic        RESET,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic [31:0]      PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic        EXT_CLK_IN,
  input  wire logic        STOP_REQ,
  output logic             GENERATOR_OUTPUT_CLOCK,
  output logic             MULTIPLIED_CLOCK,
  output logic             REFERENCE_CLOCK_OUT,
  output logic             FIXED_FREQ_ENABLE,
  output logic             DEBUG_LOCAL_CLOCK,
  output logic             RTI_TICK,
  output logic             OSC_RANGE_HIGH,
  output logic             HIGH_GAIN_SELECT,
  output logic             LOSS_RESET,
  output logic             LOSS_IRQ,
  output clkgen_pkg::mode_t MODE
);
  import clkgen_pkg::*;

  // ********************
  // registers
  // ********************
  logic [6:0]  ctrl;
  logic [6:0]  mult;
  logic [2:0]  div;
  logic [11:0] filt;
  logic [7:0]  trim;
  logic        lol_flag;
  logic        loc_flag;
  mode_t       mode;
  mode_t       next_mode;
  logic        wr;
  logic        rd;
  logic        mapped;
  logic        clr_lol;
  logic        clr_loc;

  function automatic logic hit(input logic [7:0] a);
    hit = (a == OFS_CTRL) || (a == OFS_MULT) || (a == OFS_FILT)
       || (a == OFS_STAT) || (a == OFS_TUNE);
  endfunction : hit

  assign wr = PSEL && PENABLE && PWRITE;
  assign rd = PSEL && !PENABLE && !PWRITE;
  assign mapped = hit(PADDR);
  assign PREADY = 1'b1;
  assign PSLVERR = PSEL && PENABLE && !mapped;
  assign clr_lol = wr && (PADDR == OFS_STAT) && PWDATA[ST_LOL];
  assign clr_loc = wr && (PADDR == OFS_STAT) && PWDATA[ST_LOC];

  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      ctrl <= 7'h00;
      mult <= MULT_RST;
      div  <= DIV_RST;
      filt <= FILT_RST;
      trim <= TRIM_RST;
    end else if (wr) begin
      if (PADDR == OFS_CTRL) begin
        ctrl <= PWDATA[6:0];
      end else if (PADDR == OFS_MULT) begin
        mult <= PWDATA[MULT_LSB +: 7];
        div  <= PWDATA[DIV_LSB +: 3]; // [RQ10]
      end else if (PADDR == OFS_FILT) begin
        filt <= PWDATA[FILT_LSB +: 12];
        trim <= PWDATA[TRIM_LSB +: 8]; // [RQ12]
      end
    end
  end

  assign OSC_RANGE_HIGH   = ctrl[CTRL_RANGE]; // [RQ1]
  assign HIGH_GAIN_SELECT = ctrl[CTRL_GAIN]; // [RQ14] [RQ24]

  // ********************
  // external clock watch
  // ********************
  logic        ext_m;
  logic        ext_s;
  logic        ext_p;
  logic        ext_rise;
  logic        ext_ok;
  logic [11:0] ext_age;
  logic [11:0] ext_lim;

  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      ext_m <= 1'b0;
      ext_s <= 1'b0;
      ext_p <= 1'b0;
    end else begin
      ext_m <= EXT_CLK_IN;
      ext_s <= ext_m;
      ext_p <= ext_s;
    end
  end

  assign ext_rise = ext_s && !ext_p;
  // slow crystals get the longer window before declared dead
  assign ext_lim = ctrl[CTRL_RANGE] ? 12'(EXT_LOSS_HI) : 12'(EXT_LOSS_LO);

  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      ext_age <= 12'h000;
      ext_ok  <= 1'b0;
    end else if (ext_rise) begin
      ext_age <= 12'h000;
      ext_ok  <= 1'b1;
    end else if (ext_age >= ext_lim) begin
      ext_ok  <= 1'b0; // [RQ5]
    end else begin
      ext_age <= ext_age + 12'h001;
    end
  end

  // ********************
  // internal references
  // ********************
  logic [9:0] iref_cnt;
  logic [9:0] iref_half;
  logic       iref;
  logic       iref_rise;
  logic [3:0] dbg_cnt;
  logic       dbg_clk;

  // trim is signed around its midpoint
  assign iref_half = 10'(IREF_HALF) + {{2{~trim[7]}}, ~trim[7], trim[6:0]}; // [RQ12] [RQ23]
  assign iref_rise = (iref_cnt == 10'h000) && !iref;

  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      iref_cnt <= 10'h000;
      iref     <= 1'b0;
    end else if (iref_cnt == 10'h000) begin
      iref_cnt <= iref_half; // [RQ23]
      iref     <= ~iref;
    end else begin
      iref_cnt <= iref_cnt - 10'h001;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      dbg_cnt <= 4'h0;
      dbg_clk <= 1'b0;
    end else if (dbg_cnt == 4'(DBG_HALF - 1)) begin
      dbg_cnt <= 4'h0;
      dbg_clk <= ~dbg_clk; // [RQ22]
    end else begin
      dbg_cnt <= dbg_cnt + 4'h1;
    end
  end

  // ********************
  // real-time tick
  // ********************
  logic [31:0] rti_cnt;

  // free of mode and source choice
  always_ff @(posedge SYS_CLK) begin
    if (RESET || !ctrl[CTRL_RTIEN]) begin
      rti_cnt  <= 32'h0;
      RTI_TICK <= 1'b0;
    end else if (rti_cnt == 32'(RTI_COUNT - 1)) begin
      rti_cnt  <= 32'h0;
      RTI_TICK <= 1'b1; // [RQ11]
    end else begin
      rti_cnt  <= rti_cnt + 32'h1;
      RTI_TICK <= 1'b0;
    end
  end

  // ********************
  // mode control
  // ********************
  logic [1:0] req;
  logic       engaged;
  logic       stop_off;

  assign req = ctrl[CTRL_MODE_LSB +: 2];
  assign engaged = (mode == M_FEI) || (mode == M_FEE);
  assign stop_off = STOP_REQ && ctrl[CTRL_STOPOFF];

  always_comb begin
    next_mode = mode;
    // wake goes straight to the request: a self-clocked pass would reload tune
    if (stop_off) begin
      next_mode = M_OFF; // [RQ15]
    end else if (req == REQ_SCM) begin
      next_mode = M_SCM; // [RQ16]
    end else if (req == REQ_FEI) begin
      next_mode = M_FEI; // [RQ17]
    end else if (req == REQ_FBE) begin
      // a dead external source is refused; drop back to self-clocked
      next_mode = ext_ok ? M_FBE : M_SCM; // [RQ5] [RQ19]
    end else if (ext_ok || mode == M_FEE) begin
      next_mode = M_FEE; // [RQ20]
    end else begin
      // fresh engage on a dead source waits self-clocked
      next_mode = M_SCM; // [RQ5]
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      mode <= M_SCM; // [RQ2]
    end else begin
      mode <= next_mode;
    end
  end

  assign MODE = mode;

  // ********************
  // frequency locked loop
  // ********************
  logic [15:0] tune;
  logic [15:0] phase;
  logic        tunable_core_oscillator;
  logic        dco_p;
  logic [7:0]  dco_cnt;
  logic        ref_edge;
  logic        lock;
  logic [2:0]  match_cnt;
  logic [7:0]  err;
  logic [7:0]  aerr;

  // the oscillator only moves on a reference edge, so a lost
  // reference leaves it where it was
  assign ref_edge = (mode == M_FEI) ? iref_rise
                  : (mode == M_FEE) ? ext_rise : 1'b0; // [RQ8]
  assign err  = dco_cnt - {1'b0, mult};
  assign aerr = err[7] ? (8'h00 - err) : err;
  assign tunable_core_oscillator  = phase[15];

  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      phase <= 16'h0000;
      dco_p <= 1'b0;
    end else begin
      phase <= phase + tune;
      dco_p <= tunable_core_oscillator;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (RESET || ref_edge) begin
      dco_cnt <= 8'h00;
    end else if (tunable_core_oscillator && !dco_p && dco_cnt != 8'hFF) begin
      dco_cnt <= dco_cnt + 8'h01;
    end
  end

  // not cleared by off mode: relock from stop starts close [RQ7]
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      tune <= {FILT_RST, 4'h0};
    end else if (mode == M_SCM) begin
      tune <= {filt, 4'h0}; // [RQ16]
    end else if (ref_edge && !err[7] && aerr != 8'h00) begin
      tune <= tune - TUNE_STEP; // [RQ18] [RQ21]
    end else if (ref_edge && err[7]) begin
      tune <= tune + TUNE_STEP; // [RQ18] [RQ21]
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (RESET || !engaged) begin
      lock      <= 1'b0;
      match_cnt <= 3'h0;
    end else if (mode == M_FEE && !ext_ok) begin
      lock      <= 1'b0;
      match_cnt <= 3'h0;
    end else if (ref_edge) begin
      if (aerr > 8'(LOCK_TOL)) begin
        lock      <= 1'b0;
        match_cnt <= 3'h0;
      end else if (aerr <= 8'h01 && match_cnt == 3'(LOCK_REPEAT - 1)) begin
        lock <= 1'b1; // [RQ18] [RQ21]
      end else if (aerr <= 8'h01) begin
        match_cnt <= match_cnt + 3'h1;
      end
    end
  end

  // ********************
  // supervision
  // ********************
  logic lock_p;
  logic ext_ok_p;

  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      lock_p   <= 1'b0;
      ext_ok_p <= 1'b0;
      lol_flag <= 1'b0;
      loc_flag <= 1'b0;
    end else begin
      lock_p   <= lock;
      ext_ok_p <= ext_ok;
      // set beats a same-cycle clear
      if (engaged && lock_p && !lock) begin
        lol_flag <= 1'b1; // [RQ6] [RQ25]
      end else if (clr_lol) begin
        lol_flag <= 1'b0;
      end
      if ((mode == M_FEE || mode == M_FBE) && ext_ok_p && !ext_ok) begin
        loc_flag <= 1'b1; // [RQ6] [RQ25]
      end else if (clr_loc) begin
        loc_flag <= 1'b0;
      end
    end
  end

  assign LOSS_RESET = (lol_flag || loc_flag) && ctrl[CTRL_LOSSRST]; // [RQ6]
  assign LOSS_IRQ   = (lol_flag || loc_flag) && !ctrl[CTRL_LOSSRST]; // [RQ6]

  // ********************
  // output clock path
  // ********************
  logic       src_ext;
  logic       want_ext;
  logic       sel;
  logic       sel_p;
  logic [7:0] div_cnt;
  logic [3:0] idx;
  logic       lock_seen;

  always_ff @(posedge SYS_CLK) begin
    if (RESET || mode != M_FEE) begin
      lock_seen <= 1'b0;
    end else if (lock) begin
      lock_seen <= 1'b1; // [RQ13]
    end
  end

  assign want_ext = ext_ok && ((mode == M_FBE) || (mode == M_FEE && !lock_seen)); // [RQ13]

  // swap only while both candidates are low, so no runt pulse
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      src_ext <= 1'b0;
    end else if (!ext_s && !tunable_core_oscillator) begin
      src_ext <= want_ext; // [RQ25]
    end
  end

  assign sel = src_ext ? ext_s : tunable_core_oscillator;
  // extra halving while engaged and out of lock
  assign idx = {1'b0, div} + {3'h0, engaged && !lock}; // [RQ9]

  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      sel_p   <= 1'b0;
      div_cnt <= 8'h00;
    end else begin
      sel_p <= sel;
      if (sel && !sel_p) begin
        div_cnt <= div_cnt + 8'h01; // [RQ10]
      end
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      GENERATOR_OUTPUT_CLOCK <= 1'b0;
      MULTIPLIED_CLOCK       <= 1'b0;
      REFERENCE_CLOCK_OUT    <= 1'b0;
      FIXED_FREQ_ENABLE      <= 1'b0;
      DEBUG_LOCAL_CLOCK      <= 1'b0;
    end else begin
      if (mode == M_OFF) begin
        GENERATOR_OUTPUT_CLOCK <= 1'b0; // [RQ15]
      end else if (idx == 4'h0) begin
        GENERATOR_OUTPUT_CLOCK <= sel;
      end else begin
        GENERATOR_OUTPUT_CLOCK <= div_cnt[3'(idx - 4'h1)]; // [RQ3]
      end
      MULTIPLIED_CLOCK    <= tunable_core_oscillator; // [RQ22]
      REFERENCE_CLOCK_OUT <= ext_s; // [RQ22]
      FIXED_FREQ_ENABLE   <= (mode == M_FBE) || (mode == M_FEE && lock); // [RQ22]
      DEBUG_LOCAL_CLOCK   <= dbg_clk; // [RQ22]
    end
  end

  // ********************
  // read back
  // ********************
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      PRDATA <= 32'h0;
    end else if (rd) begin
      if (PADDR == OFS_CTRL) begin
        PRDATA <= {25'h0, ctrl};
      end else if (PADDR == OFS_MULT) begin
        PRDATA <= {21'h0, div, 1'b0, mult};
      end else if (PADDR == OFS_FILT) begin
        PRDATA <= {8'h0, trim, 4'h0, filt};
      end else if (PADDR == OFS_STAT) begin
        PRDATA <= {19'h0, mode, 4'h0, ext_ok, loc_flag, lol_flag, lock};
      end else if (PADDR == OFS_TUNE) begin
        PRDATA <= {16'h0, tune};
      end else begin
        PRDATA <= 32'h0;
      end
    end
  end

  // ********************
  // checks
  // ********************
  sequence s_off_two;
    (mode == M_OFF) ##1 (mode == M_OFF);
  endsequence

  a_reset_self_clocked: assert property (@(posedge SYS_CLK) RESET |=> mode == M_SCM) // [RQ2]
    else $error("reset did not enter self-clocked mode");
  a_off_output_low: assert property (@(posedge SYS_CLK) disable iff (RESET)
    s_off_two |-> !GENERATOR_OUTPUT_CLOCK) // [RQ15]
    else $error("output moved in off mode");
  a_ext_lockout: assert property (@(posedge SYS_CLK) disable iff (RESET)
    (mode == M_FBE && $past(mode) != M_FBE) |-> $past(ext_ok)) // [RQ5]
    else $error("dead external source selected");
  a_lock_loss_flag: assert property (@(posedge SYS_CLK) disable iff (RESET)
    (engaged && lock ##1 engaged && !lock) |=> lol_flag) // [RQ6]
    else $error("loss of lock not flagged");
  a_tune_holds: assert property (@(posedge SYS_CLK) disable iff (RESET)
    (engaged && $past(engaged) && !$past(ref_edge)) |-> $stable(tune)) // [RQ8]
    else $error("oscillator moved without reference");
  a_unlock_halves: assert property (@(posedge SYS_CLK) disable iff (RESET)
    (engaged && !lock) |-> idx == {1'b0, div} + 4'h1) // [RQ9]
    else $error("missing divide by two");
  a_scm_filter: assert property (@(posedge SYS_CLK) disable iff (RESET)
    (mode == M_SCM) |=> tune == {$past(filt), 4'h0}) // [RQ16]
    else $error("self-clocked tune not from filter");
  a_off_keeps_tune: assert property (@(posedge SYS_CLK) disable iff (RESET)
    s_off_two |-> $stable(tune)) // [RQ7]
    else $error("tune lost in off mode");
  a_lock_engaged: assert property (@(posedge SYS_CLK) disable iff (RESET)
    $rose(lock) |-> $past(engaged) && $past(ref_edge)) // [RQ18]
    else $error("lock without engaged reference");
  a_flag_sticky: assert property (@(posedge SYS_CLK) disable iff (RESET)
    (loc_flag && !clr_loc) |=> loc_flag) // [RQ25]
    else $error("clock loss flag cleared itself");
endmodule : clock_generator

// *** ext_clock_model.sv ***
`timescale 1ns/100ps
// ********************
// external clock source
// ********************
module ext_clock_model (
  input  wire logic        RUN,
  input  wire logic [15:0] HALF_NS,
  output logic             EXT_CLK
);
  // a stopped crystal stands low, so no stale edge fakes a running source
  initial EXT_CLK = 1'b0;
  always begin
    if (RUN) begin
      #(HALF_NS) EXT_CLK = ~EXT_CLK;
    end else begin
      EXT_CLK = 1'b0;
      @(RUN);
    end
  end
endmodule : ext_clock_model

// *** tb.sv ***
`timescale 1ns/100ps
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin n_fail++; $display("wrong value %s expected %0h seen %0h", nm, e, g); end end
module tb;
  import clkgen_pkg::*;
  typedef struct {logic [7:0] a; logic [31:0] wd; logic [31:0] rd; logic err; logic rng; logic gain;} row_t;
  // ********************
  // signals
  // ********************
  logic        sys_clk  = 1'b0;
  logic        reset    = 1'b1;
  logic        psel     = 1'b0;
  logic        penable  = 1'b0;
  logic        pwrite   = 1'b0;
  logic [7:0]  paddr    = 8'h00;
  logic [31:0] pwdata   = 32'h00000000;
  logic        stop_req = 1'b0;
  logic        run      = 1'b0;
  logic [15:0] half_ns  = 16'h0028;
  logic [31:0] prdata, rd, t0;
  logic        pready, pslverr, err, ext_clk, gen_clk, mul_clk, ref_clk, ffe, dbg_clk, rti, rng, gain;
  logic        loss_rst, loss_irq;
  mode_t       mode;
  int          n_fail   = 0;
  int          checked  = 0;
  int          c;
  row_t rows[6] = '{
    '{OFS_CTRL, 32'h00000008, 32'h00000008, 1'b0, 1'b0, 1'b1},
    '{OFS_MULT, 32'h00000305, 32'h00000305, 1'b0, 1'b0, 1'b1},
    '{OFS_FILT, 32'h00900400, 32'h00900400, 1'b0, 1'b0, 1'b1},
    '{8'h14,    32'hFFFFFFFF, 32'h00000000, 1'b1, 1'b0, 1'b1},
    '{OFS_STAT, 32'h00000006, 32'h00000200, 1'b0, 1'b0, 1'b1},
    '{OFS_CTRL, 32'h00000004, 32'h00000004, 1'b0, 1'b1, 1'b0}};
  always #5 sys_clk = ~sys_clk;
  clock_generator #(.RTI_COUNT(50)) dut (.SYS_CLK(sys_clk), .RESET(reset), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .EXT_CLK_IN(ext_clk), .STOP_REQ(stop_req), .GENERATOR_OUTPUT_CLOCK(gen_clk), .MULTIPLIED_CLOCK(mul_clk),
    .REFERENCE_CLOCK_OUT(ref_clk), .FIXED_FREQ_ENABLE(ffe), .DEBUG_LOCAL_CLOCK(dbg_clk), .RTI_TICK(rti),
    .OSC_RANGE_HIGH(rng), .HIGH_GAIN_SELECT(gain), .LOSS_RESET(loss_rst), .LOSS_IRQ(loss_irq), .MODE(mode));
  ext_clock_model ext (.RUN(run), .HALF_NS(half_ns), .EXT_CLK(ext_clk));
  // ********************
  // tasks
  // ********************
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : cyc
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  function automatic logic pick(input int sel);
    return sel == 0 ? gen_clk : sel == 1 ? dbg_clk : sel == 2 ? rti : sel == 3 ? ref_clk : mul_clk;
  endfunction : pick
  task automatic rises(input int sel, input int n, output int cnt);
    logic p;
    cnt = 0;
    p = pick(sel);
    repeat (n) begin
      @(posedge sys_clk);
      if (pick(sel) === 1'b1 && p === 1'b0) cnt++;
      p = pick(sel);
    end
  endtask : rises
  // lock time depends on oscillator slew, so poll under a bound
  task automatic wait_lock;
    int k = 0;
    rd = 32'h0;
    while (rd[ST_LOCK] !== 1'b1 && k < 4000) begin
      apb(1'b0, OFS_STAT, 32'h0);
      k++;
    end
  endtask : wait_lock
  task automatic done(input string s);
    $display("test %s done", s);
  endtask : done
  task automatic finish_test;
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : finish_test
  // ********************
  // watchdog
  // ********************
  initial begin
    cyc(95000);
    n_fail++;
    $display("watchdog expired");
    finish_test();
  end
  // ********************
  // tests
  // ********************
  initial begin
    cyc(2);
    reset <= 1'b0;
    cyc(1);
    `CHK("mode", M_SCM, mode)
    apb(1'b0, OFS_MULT, 32'h0);
    `CHK("mult", {21'h0, DIV_RST, 1'b0, MULT_RST}, rd)
    apb(1'b0, OFS_FILT, 32'h0);
    `CHK("filt", {8'h00, TRIM_RST, 4'h0, FILT_RST}, rd)
    done("reset");
    foreach (rows[i]) begin
      apb(1'b1, rows[i].a, rows[i].wd);
      apb(1'b0, rows[i].a, 32'h0);
      `CHK("rdata", rows[i].rd, rd)
      `CHK("slverr", rows[i].err, err)
      `CHK("range", rows[i].rng, rng)
      `CHK("gain", rows[i].gain, gain)
    end
    apb(1'b1, OFS_FILT, 32'h00800400);
    apb(1'b1, OFS_MULT, 32'h00000008);
    done("registers");
    // bypass requested while the source is dead must be refused
    apb(1'b1, OFS_CTRL, 32'h00000006);
    cyc(20);
    `CHK("mode", M_SCM, mode)
    run <= 1'b1;
    cyc(20);
    apb(1'b1, OFS_CTRL, 32'h00000006);
    cyc(20);
    `CHK("mode", M_FBE, mode)
    `CHK("ffe", 1'b1, ffe)
    rises(3, 64, c);
    `CHK("refclk", 1'b1, (c >= 7 && c <= 9))
    for (int d = 0; d < 8; d++) begin
      apb(1'b1, OFS_MULT, 32'h00000008 | (32'(d) << 8));
      cyc(4);
      rises(0, 64 << d, c);
      `CHK("div", 1'b1, (c >= 7 && c <= 9))
    end
    apb(1'b1, OFS_MULT, 32'h00000008);
    done("bypass");
    run <= 1'b0;
    cyc(260);
    `CHK("mode", M_SCM, mode)
    `CHK("irq", 1'b1, loss_irq)
    `CHK("rst", 1'b0, loss_rst)
    apb(1'b0, OFS_STAT, 32'h0);
    `CHK("loc", 1'b1, rd[ST_LOC])
    apb(1'b1, OFS_STAT, 32'h00000006);
    cyc(2);
    `CHK("irq", 1'b0, loss_irq)
    run <= 1'b1;
    cyc(20);
    apb(1'b1, OFS_CTRL, 32'h00000016);
    cyc(20);
    run <= 1'b0;
    cyc(260);
    `CHK("rst", 1'b1, loss_rst)
    apb(1'b1, OFS_STAT, 32'h00000006);
    done("loss");
    // start the oscillator near 8 times the reference so lock comes fast
    apb(1'b1, OFS_FILT, 32'h0080019A);
    // 1.25 MHz times 8 keeps the loop far below its ceiling
    half_ns <= 16'h0190;
    run <= 1'b1;
    cyc(20);
    apb(1'b1, OFS_CTRL, 32'h00000007);
    wait_lock();
    `CHK("lock", 1'b1, rd[ST_LOCK])
    `CHK("mode", M_FEE, mode)
    `CHK("ffe", 1'b1, ffe)
    run <= 1'b0;
    cyc(300);
    `CHK("mode", M_FEE, mode)
    apb(1'b0, OFS_TUNE, 32'h0);
    t0 = rd;
    rises(0, 200, c);
    `CHK("halved", 1'b1, (c >= 9 && c <= 11))
    apb(1'b0, OFS_TUNE, 32'h0);
    `CHK("tune", t0, rd)
    apb(1'b0, OFS_STAT, 32'h0);
    `CHK("loc", 1'b1, rd[ST_LOC])
    apb(1'b1, OFS_STAT, 32'h00000006);
    done("engaged external");
    // pass through self-clocked so the oscillator starts near 8 times the slow reference
    apb(1'b1, OFS_FILT, 32'h00800050);
    apb(1'b1, OFS_CTRL, 32'h00000000);
    apb(1'b1, OFS_CTRL, 32'h00000001);
    wait_lock();
    `CHK("lock", 1'b1, rd[ST_LOCK])
    `CHK("mode", M_FEI, mode)
    rises(4, 412, c);
    `CHK("mulclk", 1'b1, (c >= 7 && c <= 9))
    apb(1'b1, OFS_CTRL, 32'h00000021);
    stop_req <= 1'b1;
    cyc(5);
    `CHK("mode", M_OFF, mode)
    apb(1'b0, OFS_TUNE, 32'h0);
    t0 = rd;
    rises(0, 100, c);
    `CHK("static", 0, c)
    apb(1'b0, OFS_TUNE, 32'h0);
    `CHK("tune", t0, rd)
    stop_req <= 1'b0;
    cyc(5);
    `CHK("wake", M_FEI, mode)
    done("off");
    reset <= 1'b1;
    cyc(2);
    reset <= 1'b0;
    cyc(1);
    `CHK("mode", M_SCM, mode)
    apb(1'b0, OFS_CTRL, 32'h0);
    `CHK("ctrl", 32'h00000000, rd)
    apb(1'b1, OFS_CTRL, 32'h00000040);
    rises(2, 500, c);
    `CHK("rti", 1'b1, (c >= 9 && c <= 11))
    rises(1, 120, c);
    `CHK("dbgclk", 1'b1, (c >= 9 && c <= 11))
    done("second reset");
    finish_test();
  end
endmodule : tb
